// ### nand_host_pkg.sv
// Shared constants, types and helpers for the NAND flash host controller.
package nand_host_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_BITS  = 26;
    localparam int COUNT_BITS = 10;
    localparam int ADDR_CYCLES = 4;

    // ------------------------------------------------------------------
    // Command bytes placed on the shared bus lines
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ_LOW  = 8'h00;
    localparam logic [7:0] CMD_READ_HIGH = 8'h01;
    localparam logic [7:0] CMD_READ_SPARE = 8'h50;
    localparam logic [7:0] CMD_READ_IDENT = 8'h90;
    localparam logic [7:0] CMD_RESET     = 8'hFF;
    localparam logic [7:0] CMD_PROG_LOAD = 8'h80;
    localparam logic [7:0] CMD_PROG_GO   = 8'h10;
    localparam logic [7:0] CMD_ERASE_SET = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
    localparam logic [7:0] CMD_STATUS    = 8'h70;

    // Number of bytes returned by an identification read.
    localparam logic [COUNT_BITS-1:0] IDENT_BYTES  = 10'h002;
    localparam logic [COUNT_BITS-1:0] STATUS_BYTES = 10'h001;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 25;
    localparam int READ_CYCLE_MIN_NS  = 30;
    localparam int READ_CYCLE_MIN_CYC = (READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Output access delay of the part; the figure is a plain default.
    localparam int ACCESS_DELAY_NS    = 20;
    // Clock cycles per bus phase; four phases make one strobe cycle.
    localparam int PHASE_DIV          = 2;
    // Ticks waited after a busy-starting strobe before trusting ready/busy.
    localparam logic [2:0] BUSY_GUARD_TICKS = 3'h4;
    // Reset state of the shared bus lines.
    localparam logic [7:0] BUS_IDLE = 8'h00;

    // ------------------------------------------------------------------
    // Operations and controller states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_SPARE   = 3'h1,
        OP_IDENT   = 3'h2,
        OP_STATUS  = 3'h3,
        OP_PROGRAM = 3'h4,
        OP_ERASE   = 3'h5,
        OP_RESET   = 3'h6
    } op_type;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_COMMAND  = 7'h02,
        ST_ADDRESS  = 7'h04,
        ST_DATA_IN  = 7'h08,
        ST_CONFIRM  = 7'h10,
        ST_WAIT     = 7'h20,
        ST_DATA_OUT = 7'h40
    } state_type;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte sent in address cycle idx; bit 8 never travels.
    function automatic logic [7:0] addr_byte(input logic [1:0] idx,
                                             input logic [ADDR_BITS-1:0] addr);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            2'h0: b = addr[7:0];
            2'h1: b = addr[16:9];
            2'h2: b = addr[24:17];
            default: b = {7'h00, addr[25]};
        endcase
        return b;
    endfunction : addr_byte

    // Opening command byte for an operation.
    function automatic logic [7:0] first_cmd(input op_type op,
                                             input logic [ADDR_BITS-1:0] addr);
        logic [7:0] c;
        c = CMD_STATUS;
        case (op)
            OP_READ:    c = addr[8] ? CMD_READ_HIGH : CMD_READ_LOW;
            OP_SPARE:   c = CMD_READ_SPARE;
            OP_IDENT:   c = CMD_READ_IDENT;
            OP_PROGRAM: c = CMD_PROG_LOAD;
            OP_ERASE:   c = CMD_ERASE_SET;
            OP_RESET:   c = CMD_RESET;
            default:    c = CMD_STATUS;
        endcase
        return c;
    endfunction : first_cmd

    // True for operations that alter the array.
    function automatic logic is_modify(input op_type op);
        return (op == OP_PROGRAM) || (op == OP_ERASE);
    endfunction : is_modify

endpackage : nand_host_pkg

// ### tick_divider.sv
// Divider that produces a one-cycle enable pulse every DIV clock cycles.
`timescale 1ns/10ps
module tick_divider #(
    parameter int DIV = 2
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    output logic      tick_o
);

    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_tick;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Count down and pulse when the count wraps.
    always_comb begin
        if (count == 8'h00) begin
            next_count = 8'(DIV - 1);
            next_tick  = 1'b1;
        end else begin
            next_count = count - 8'h01;
            next_tick  = 1'b0;
        end
    end

    // Register only.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count  <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            count  <= next_count;
            tick_o <= next_tick;
        end
    end

endmodule : tick_divider

// ### nand_host.sv
// Host controller that drives a byte-wide NAND flash through its pins.
`timescale 1ns/10ps
module nand_host
    import nand_host_pkg::*;
#(
    parameter int DIV = nand_host_pkg::PHASE_DIV
) (
    input  wire logic                                CORE_CLK_I,
    input  wire logic                                NRST_I,
    input  wire logic                                START_I,
    input  wire nand_host_pkg::op_type               OP_I,
    input  wire logic [nand_host_pkg::ADDR_BITS-1:0] ADDR_I,
    input  wire logic [nand_host_pkg::COUNT_BITS-1:0] COUNT_I,
    input  wire logic                                ALLOW_MODIFY_I,
    input  wire logic [7:0]                          WR_DATA_I,
    output logic                                     WR_TAKE_O,
    output logic [7:0]                               RD_DATA_O,
    output logic                                     RD_VALID_O,
    output logic                                     BUSY_O,
    output logic                                     REFUSED_O,
    output logic                                     CE_N_O,
    output logic                                     CLE_O,
    output logic                                     ALE_O,
    output logic                                     WE_N_O,
    output logic                                     OUTPUT_STROBE_N_O,
    output logic                                     MODIFY_LOCK_N_O,
    input  wire logic [7:0]                          SHARED_BUS_LINES_I,
    output logic [7:0]                               SHARED_BUS_LINES_O,
    output logic                                     SHARED_BUS_LINES_OE_N_O,
    input  wire logic                                READY_BUSY_I
);
    import nand_host_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic       rb_meta;
    logic       rb_sync;
    logic [7:0] bus_meta;
    logic [7:0] bus_sync;

    // Ready/busy may be a wired line shared by several parts; only its level matters.
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rb_meta  <= 1'b0;
            rb_sync  <= 1'b0;
            bus_meta <= BUS_IDLE;
            bus_sync <= BUS_IDLE;
        end else begin
            rb_meta  <= READY_BUSY_I;
            rb_sync  <= rb_meta;
            bus_meta <= SHARED_BUS_LINES_I;
            bus_sync <= bus_meta;
        end
    end

    logic tick;

    tick_divider #(
        .DIV    (DIV)
    ) u_tick (
        .clk_i  (CORE_CLK_I),
        .nrst_i (NRST_I),
        .tick_o (tick)
    );

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    state_type                state,     next_state;
    op_type                   op,        next_op;
    logic [1:0]               phase,     next_phase;
    logic [1:0]               idx,       next_idx;
    logic [COUNT_BITS-1:0]    count,     next_count;
    logic [2:0]               guard,     next_guard;
    logic [ADDR_BITS-1:0]     addr,      next_addr;
    logic [7:0]               cmd_byte,  next_cmd_byte;
    logic                     ce_n,      next_ce_n;
    logic                     cle,       next_cle;
    logic                     ale,       next_ale;
    logic                     we_n,      next_we_n;
    logic                     re_n,      next_re_n;
    logic                     wp_n,      next_wp_n;
    logic [7:0]               bus_out,   next_bus_out;
    logic                     bus_oe_n,  next_bus_oe_n;
    logic [7:0]               rd_data,   next_rd_data;
    logic                     rd_valid,  next_rd_valid;
    logic                     wr_take,   next_wr_take;
    logic                     busy,      next_busy;
    logic                     refused,   next_refused;

    // Next values. Every bus cycle has four phases: set up, strobe low,
    // hold low, strobe high. The slow phase rate keeps the output strobe
    // low long enough for the access delay plus the two synchroniser stages.
    always_comb begin
        next_state    = state;
        next_op       = op;
        next_phase    = phase;
        next_idx      = idx;
        next_count    = count;
        next_guard    = guard;
        next_addr     = addr;
        next_cmd_byte = cmd_byte;
        next_ce_n     = ce_n;
        next_cle      = cle;
        next_ale      = ale;
        next_we_n     = we_n;
        next_re_n     = re_n;
        next_wp_n     = wp_n;
        next_bus_out  = bus_out;
        next_bus_oe_n = bus_oe_n;
        next_rd_data  = rd_data;
        next_rd_valid = 1'b0;
        next_wr_take  = 1'b0;
        next_busy     = busy;
        next_refused  = 1'b0;
        case (state)
            ST_IDLE: begin
                if (START_I) begin
                    if (is_modify(OP_I) && !ALLOW_MODIFY_I) begin
                        next_refused = 1'b1;
                    end else if (rb_sync || OP_I == OP_STATUS || OP_I == OP_RESET) begin
                        next_state    = ST_COMMAND;
                        next_op       = OP_I;
                        next_addr     = ADDR_I;
                        next_count    = (COUNT_I == '0) ? 10'h001 : COUNT_I;
                        next_cmd_byte = first_cmd(OP_I, ADDR_I);
                        next_phase    = 2'h0;
                        next_idx      = 2'h0;
                        next_busy     = 1'b1;
                        next_ce_n     = 1'b0;
                        next_wp_n     = ALLOW_MODIFY_I;
                    end
                end
            end
            ST_WAIT: begin
                if (tick) begin
                    next_cle      = 1'b0;
                    next_ale      = 1'b0;
                    next_bus_oe_n = 1'b1;
                    if (guard != BUSY_GUARD_TICKS) begin
                        next_guard = guard + 3'h1;
                    end else if (rb_sync) begin
                        next_phase = 2'h0;
                        if (op == OP_READ || op == OP_SPARE) begin
                            next_state = ST_DATA_OUT;
                        end else begin
                            next_state = ST_IDLE;
                            next_busy  = 1'b0;
                            next_ce_n  = 1'b1;
                        end
                    end
                end
            end
            default: begin
                if (tick) begin
                    next_phase = phase + 2'h1;
                    case (phase)
                        2'h0: begin
                            // Only one latch strobe is high at a time.
                            next_cle      = (state == ST_COMMAND) || (state == ST_CONFIRM);
                            next_ale      = (state == ST_ADDRESS);
                            next_bus_oe_n = (state == ST_DATA_OUT);
                            if (state == ST_ADDRESS) begin
                                next_bus_out = addr_byte(idx, addr);
                            end else if (state == ST_DATA_IN) begin
                                next_bus_out = WR_DATA_I;
                                next_wr_take = 1'b1;
                            end else if (state != ST_DATA_OUT) begin
                                next_bus_out = cmd_byte;
                            end
                        end
                        2'h1: begin
                            if (state == ST_DATA_OUT) begin
                                next_re_n = 1'b0;
                            end else begin
                                next_we_n = 1'b0;
                            end
                        end
                        2'h2: begin
                        end
                        default: begin
                            next_we_n = 1'b1;
                            next_re_n = 1'b1;
                            next_guard = 3'h0;
                            case (state)
                                ST_COMMAND: begin
                                    if (op == OP_IDENT || op == OP_STATUS) begin
                                        next_state = ST_DATA_OUT;
                                        next_count = (op == OP_IDENT) ? IDENT_BYTES : STATUS_BYTES;
                                    end else if (op == OP_RESET) begin
                                        next_state = ST_WAIT;
                                    end else begin
                                        next_state = ST_ADDRESS;
                                    end
                                end
                                ST_ADDRESS: begin
                                    next_idx = idx + 2'h1;
                                    if (idx == 2'(ADDR_CYCLES - 1)) begin
                                        if (op == OP_PROGRAM) begin
                                            next_state = ST_DATA_IN;
                                        end else if (op == OP_ERASE) begin
                                            next_state    = ST_CONFIRM;
                                            next_cmd_byte = CMD_ERASE_GO;
                                        end else begin
                                            next_state = ST_WAIT;
                                        end
                                    end
                                end
                                ST_DATA_IN: begin
                                    next_count = count - 10'h001;
                                    if (count == 10'h001) begin
                                        next_state    = ST_CONFIRM;
                                        next_cmd_byte = CMD_PROG_GO;
                                    end
                                end
                                ST_CONFIRM: begin
                                    next_state = ST_WAIT;
                                end
                                default: begin
                                    // Byte is sampled just before the strobe rises.
                                    next_rd_data  = bus_sync;
                                    next_rd_valid = 1'b1;
                                    next_count    = count - 10'h001;
                                    if (count == 10'h001) begin
                                        next_state = ST_IDLE;
                                        next_busy  = 1'b0;
                                        next_ce_n  = 1'b1;
                                    end
                                end
                            endcase
                        end
                    endcase
                end
            end
        endcase
    end

    // Register only. The modify lock starts asserted so nothing changes the
    // array until software allows it.
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state    <= ST_IDLE;
            op       <= OP_STATUS;
            phase    <= 2'h0;
            idx      <= 2'h0;
            count    <= '0;
            guard    <= 3'h0;
            addr     <= '0;
            cmd_byte <= CMD_STATUS;
            ce_n     <= 1'b1;
            cle      <= 1'b0;
            ale      <= 1'b0;
            we_n     <= 1'b1;
            re_n     <= 1'b1;
            wp_n     <= 1'b0;
            bus_out  <= BUS_IDLE;
            bus_oe_n <= 1'b1;
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
            wr_take  <= 1'b0;
            busy     <= 1'b0;
            refused  <= 1'b0;
        end else begin
            state    <= next_state;
            op       <= next_op;
            phase    <= next_phase;
            idx      <= next_idx;
            count    <= next_count;
            guard    <= next_guard;
            addr     <= next_addr;
            cmd_byte <= next_cmd_byte;
            ce_n     <= next_ce_n;
            cle      <= next_cle;
            ale      <= next_ale;
            we_n     <= next_we_n;
            re_n     <= next_re_n;
            wp_n     <= next_wp_n;
            bus_out  <= next_bus_out;
            bus_oe_n <= next_bus_oe_n;
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
            wr_take  <= next_wr_take;
            busy     <= next_busy;
            refused  <= next_refused;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign CE_N_O                  = ce_n;
    assign CLE_O                   = cle;
    assign ALE_O                   = ale;
    assign WE_N_O                  = we_n;
    assign OUTPUT_STROBE_N_O       = re_n;
    assign MODIFY_LOCK_N_O         = wp_n;
    assign SHARED_BUS_LINES_O      = bus_out;
    assign SHARED_BUS_LINES_OE_N_O = bus_oe_n;
    assign RD_DATA_O               = rd_data;
    assign RD_VALID_O              = rd_valid;
    assign WR_TAKE_O               = wr_take;
    assign BUSY_O                  = busy;
    assign REFUSED_O               = refused;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_we_rise;
        $rose(we_n);
    endsequence
    sequence s_re_low_hold;
        !re_n ##1 !re_n;
    endsequence

    a_bus_driven_write: assert property (!we_n |-> !bus_oe_n && !ce_n)
        else $error("write strobe low while bus not driven");
    a_cmd_latch_sel: assert property (s_we_rise and cle |-> !ale && !ce_n && re_n)
        else $error("command latched with wrong strobes");
    a_addr_latch_sel: assert property (s_we_rise and ale |-> !cle && !ce_n && re_n)
        else $error("address latched with wrong strobes");
    a_addr_mid_order: assert property (s_we_rise and ale && $past(idx) == 2'h1
        |-> bus_out == addr[16:9])
        else $error("second address cycle carries wrong bits");
    a_addr_top_cycle: assert property (s_we_rise and ale && $past(idx) == 2'h3
        |-> bus_out == {7'h00, addr[25]})
        else $error("fourth address cycle malformed");
    a_modify_lock_go: assert property (s_we_rise and cle
        && (bus_out == CMD_PROG_GO || bus_out == CMD_ERASE_GO) |-> wp_n)
        else $error("modify confirm issued while locked");
    a_read_strobe_hold: assert property ($fell(re_n) |-> s_re_low_hold)
        else $error("output strobe low shorter than 30 ns");
    a_start_when_ready: assert property (state == ST_COMMAND && $past(state) == ST_IDLE
        && op != OP_STATUS && op != OP_RESET |-> $past(rb_sync))
        else $error("operation started while part busy");

endmodule : nand_host

// ### nand_dev_model.sv
// Behavioural model of the byte-wide flash device.
`timescale 1ns/10ps
module nand_dev_model #(
    parameter logic [7:0] MAKER = 8'h5A, // Arbitrary identity value.
    parameter logic [7:0] DEVICE = 8'hA5 // Arbitrary identity value.
) (
    input  wire logic ce_n_i, cle_i, ale_i, we_n_i, re_n_i, wp_n_i,
    input  wire logic [7:0] bus_i,
    output logic [7:0]      bus_o,
    output logic            rb_o = 1'b1,
    output logic [7:0]      cmd_o = 8'h00,
    output logic [31:0]     adr_o = 32'h0
);
    logic [7:0] col = 8'h00, q = 8'h00;
    logic       drv = 1'b0, idc = 1'b0;
    int         na = 0;
    // Capture on the write strobe rise; busy starts only where allowed.
    always @(posedge we_n_i) if (!ce_n_i) begin
        if (cle_i) begin
            cmd_o = bus_i;
            idc = 1'b0;
            na = 0;
            if (bus_i == 8'hFF || (wp_n_i && (bus_i == 8'h10 || bus_i == 8'hD0))) begin
                rb_o <= #5 1'b0;
                rb_o <= #900 1'b1;
            end
        end else if (ale_i) begin
            adr_o = {adr_o[23:0], bus_i};
            na++;
            if (na == 4) col = adr_o[31:24];
            if (na == 4 && cmd_o inside {8'h00, 8'h01, 8'h50}) begin
                rb_o <= #5 1'b0;
                rb_o <= #900 1'b1;
            end
        end
    end
    // Each output strobe fall presents the next byte.
    always @(negedge re_n_i) if (!ce_n_i) begin
        q = (cmd_o == 8'h90) ? (idc ? DEVICE : MAKER) : (cmd_o == 8'h70) ? 8'hE0 : col;
        idc = 1'b1;
        col = col + 8'h01;
        drv = 1'b1;
    end
    always @(posedge re_n_i) drv = 1'b0;
    // A released bus shows the inverse so stale data never passes.
    assign bus_o = (drv && !ce_n_i) ? q : ~q;
endmodule : nand_dev_model

// ### tb_top.sv
// Self-checking bench for the flash host controller.
`timescale 1ns/10ps
module tb_top;
    import nand_host_pkg::*;
    typedef struct {op_type op; logic [25:0] a; logic [9:0] n;} row_type;
    row_type rows[5] = '{'{OP_READ, 26'h1234510, 10'h003}, '{OP_READ, 26'h2ABC0F0, 10'h002},
        '{OP_SPARE, 26'h0000005, 10'h002}, '{OP_IDENT, 26'h0, 10'h002}, '{OP_STATUS, 26'h0, 10'h001}};
    logic clk = 1'b0, nrst = 1'b0, start = 1'b0, allow = 1'b0;
    op_type op = OP_STATUS;
    logic [25:0] adr = 26'h0;
    logic [9:0] cnt = 10'h000;
    logic [7:0] rdd, ho, dvo, lines, dcmd;
    logic [31:0] dadr;
    logic take, rdv, busy, refd, ce_n, cle, ale, we_n, re_n, lk_n, oe_n, rb;
    int miscompares = 0, checks_done = 0, nb = 0, cyc = 0, nt = 0;
    op_type cur_op;
    logic [25:0] cur_a;
    assign lines = oe_n ? dvo : ho;
    nand_host i_dut (.CORE_CLK_I(clk), .NRST_I(nrst), .START_I(start), .OP_I(op),
        .ADDR_I(adr), .COUNT_I(cnt), .ALLOW_MODIFY_I(allow), .WR_DATA_I(8'h3C),
        .WR_TAKE_O(take), .RD_DATA_O(rdd), .RD_VALID_O(rdv), .BUSY_O(busy), .REFUSED_O(refd),
        .CE_N_O(ce_n), .CLE_O(cle), .ALE_O(ale), .WE_N_O(we_n), .OUTPUT_STROBE_N_O(re_n),
        .MODIFY_LOCK_N_O(lk_n), .SHARED_BUS_LINES_I(lines), .SHARED_BUS_LINES_O(ho),
        .SHARED_BUS_LINES_OE_N_O(oe_n), .READY_BUSY_I(rb));
    nand_dev_model i_mem (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
        .re_n_i(re_n), .wp_n_i(lk_n), .bus_i(lines), .bus_o(dvo), .rb_o(rb), .cmd_o(dcmd),
        .adr_o(dadr));
    // Clock at 40 MHz.
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic complete_run;
        if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    function automatic logic [7:0] expv(input int i);
        if (cur_op == OP_IDENT) return i ? 8'hA5 : 8'h5A;
        if (cur_op == OP_STATUS) return 8'hE0;
        return cur_a[7:0] + i[7:0];
    endfunction : expv
    // Every delivered byte is compared at the falling edge, while its flag stands.
    // Sampling away from the rising edge keeps the count settled when a task reads it.
    always @(negedge clk) if (rdv === 1'b1) begin
        chk(rdd === expv(nb), "read byte");
        nb++;
    end
    // Program bytes taken by the host are counted the same way.
    always @(negedge clk) if (take === 1'b1) nt++;
    // Request one operation and wait, bounded, for its end.
    task automatic go(input op_type o, input logic [25:0] a, input logic [9:0] n);
        cur_op = o;
        cur_a = a;
        nb = 0;
        nt = 0;
        @(posedge clk);
        start <= 1'b1; op <= o; adr <= a; cnt <= n;
        for (int k = 0; k < 20 && busy !== 1'b1; k++) @(posedge clk);
        start <= 1'b0;
        for (cyc = 0; cyc < 4000 && busy !== 1'b0; cyc++) @(posedge clk);
        chk(cyc < 4000 && busy === 1'b0, "operation end");
    endtask : go
    initial begin
        repeat (6) @(posedge clk);
        chk(ce_n === 1'b1 && lk_n === 1'b0 && busy === 1'b0 && oe_n === 1'b1, "reset pins");
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[r]) begin
            go(rows[r].op, rows[r].a, rows[r].n);
            chk(nb === int'(rows[r].n), "byte count");
            if (rows[r].op == OP_READ) begin
                chk(dcmd === (rows[r].a[8] ? 8'h01 : 8'h00), "read cmd");
                chk(dadr === {rows[r].a[7:0], rows[r].a[16:9], rows[r].a[24:17], 7'h00, rows[r].a[25]}, "addr bytes");
                chk(cyc > 4 * PHASE_DIV * (4 + int'(rows[r].n)) + 36, "busy wait");
            end
        end
        @(posedge clk);
        start <= 1'b1; op <= OP_PROGRAM;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        chk(refd === 1'b1 && busy === 1'b0, "locked program");
        allow <= 1'b1;
        go(OP_ERASE, 26'h0123400, 10'h001);
        chk(dcmd === CMD_ERASE_GO && lk_n === 1'b1 && cyc > 4 * PHASE_DIV * 5 + 36, "erase");
        go(OP_PROGRAM, 26'h0456700, 10'h003);
        chk(dcmd === CMD_PROG_GO && nt === 3 && cyc > 4 * PHASE_DIV * 8 + 36, "program");
        go(OP_RESET, 26'h0, 10'h000);
        chk(dcmd === CMD_RESET && cyc > 36, "reset op");
        // Reset in mid-run, while a read waits on the busy part.
        @(posedge clk);
        start <= 1'b1;
        op <= OP_READ;
        adr <= 26'h0000020;
        cnt <= 10'h004;
        repeat (2) @(posedge clk);
        start <= 1'b0;
        repeat (50) @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        chk(ce_n === 1'b1 && busy === 1'b0 && lk_n === 1'b0 && re_n === 1'b1, "mid reset");
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        go(OP_STATUS, 26'h0, 10'h001);
        chk(nb === 1, "status after reset");
        complete_run();
    end
    // Watchdog well beyond the expected run.
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
endmodule : tb_top
